// *** npic_pkg.sv ***
// shared constants and types for the nested priority interrupt controller
package npic_pkg;

  localparam int          NUM_VEC        = 14;
  localparam int          MAX_VEC        = 16;
  localparam int          PINS_PER_VEC   = 4;
  localparam int          NUM_PRIO_REGS  = 4;
  localparam int          PAIRS_PER_REG  = 4;

  localparam int          CC_PRIO_HI_POS = 5;
  localparam int          CC_PRIO_LO_POS = 3;
  localparam logic [7:0]  CC_RESET       = 8'hea;
  localparam logic [7:0]  CC_FIXED_ONES  = 8'hc0;

  localparam logic [1:0]  LVL0_CODE      = 2'h2;
  localparam logic [1:0]  LVL1_CODE      = 2'h1;
  localparam logic [1:0]  LVL2_CODE      = 2'h0;
  localparam logic [1:0]  LVL3_CODE      = 2'h3;

  localparam logic [7:0]  PRIO_RESET     = 8'hff;
  localparam logic [7:0]  PRIO_RO_MASK   = 8'hf0;
  localparam int          PRIO_RO_REG    = 3;

  localparam logic [15:0] VEC_RESET      = 16'hfffe;
  localparam logic [15:0] VEC_TRAP       = 16'hfffc;
  localparam logic [15:0] VEC_BASE       = 16'hfffa;

  localparam logic [13:0] EXT_MASK_DEF   = 14'h003c;
  localparam logic [13:0] HALT_WAKE_DEF  = 14'h00bc;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN,
    ST_WAIT,
    ST_HALT
  } npic_state_t;

  // maps the two-bit level code onto a numeric rank, 0 lowest
  function automatic logic [1:0] npic_rank(input logic [1:0] code);
    logic [1:0] r;
    r = 2'h0;
    unique case (code)
      LVL0_CODE: r = 2'h0;
      LVL1_CODE: r = 2'h1;
      LVL2_CODE: r = 2'h2;
      LVL3_CODE: r = 2'h3;
    endcase
    return r;
  endfunction

endpackage

// *** npic_arb_if.sv ***
// arbitration carrier between the controller and its arbiter
`timescale 1ns/100ps
interface npic_arb_if #(
  parameter int NV = 14
);
  logic [NV-1:0]   req;
  logic [2*NV-1:0] lvl;
  logic [1:0]      curRank;
  logic            valid;
  logic [3:0]      idx;
  logic [1:0]      winRank;

  modport ctrl (output req, output lvl, output curRank, input valid, input idx, input winRank);
  modport arb  (input req, input lvl, input curRank, output valid, output idx, output winRank);
endinterface

// *** npic_arbiter.sv ***
// two-step selection: highest software level, then highest hardware order
`timescale 1ns/100ps
module npic_arbiter #(
  parameter int NV = 14
) (
  npic_arb_if.arb arb
);

  always_comb begin
    logic [1:0] r;
    logic       found;
    r = 2'h0;
    found = 1'b0;
    arb.valid = 1'b0;
    arb.idx = 4'h0;
    arb.winRank = 2'h0;
    // walk from lowest hardware order up, so ties go to the lower index
    for (int i = NV - 1; i >= 0; i--) begin
      r = npic_pkg::npic_rank(arb.lvl[2*i +: 2]);
      if (arb.req[i] && (r > arb.curRank) && (!found || r >= arb.winRank)) begin // RL8 RL10 RL13
        found = 1'b1;
        arb.valid = 1'b1;
        arb.idx = 4'(i);
        arb.winRank = r;
      end
    end
  end

endmodule // npic_arbiter

// *** npic_ctrl.sv ***
// nested priority interrupt controller, top level
// Overview of operation
// RL1 - priority bits sit at cc bits 5,3
// RL2 - up to sixteen fixed vectors, four levels
// RL3 - entry only at an instruction boundary
// RL4 - entry asks cpu to push pc,x,a,cc
// RL5 - maskable entry loads the vector's level
// RL6 - entry hands out the vector fetch address
// RL7 - return restores cc including priority bits
// RL8 - highest level wins, then hardware order
// RL9 - unserviced requests stay latched until chosen
// RL10 - hardware order unique, levels may be shared
// RL11 - reset and trap unmaskable, set level three
// RL12 - reset and trap leave halt; here only reset does, trap is taken in ST_RUN only
// RL13 - serve only enabled, strictly higher-level requests
// RL14 - edge requests latched, cleared on entry
// RL15 - selected pins of a group ORed
// RL16 - peripheral request needs flag and enable
// RL17 - clearing sequence drops the pending latch
// RL18 - all wake wait, designated ones wake halt
// RL19 - first after halt must be halt-capable
// RL20 - level instructions may rewrite priority bits
// RL21 - cc resets with both priority bits set
// RL22 - reset has top hardware and software level
// RL23 - four priority registers, reset ones
// RL24 - writes of level-zero code are ignored
// RL25 - arbitration redone at every instruction boundary
`timescale 1ns/100ps
module npic_ctrl #(
  parameter int          NV        = npic_pkg::NUM_VEC,
  parameter int          PINS      = npic_pkg::PINS_PER_VEC,
  parameter logic [13:0] EXT_MASK  = npic_pkg::EXT_MASK_DEF,
  parameter logic [13:0] HALT_WAKE = npic_pkg::HALT_WAKE_DEF
) (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               instrDone,
  input  wire logic               trapInstr,
  input  wire logic               haltInstr,
  input  wire logic               wfiInstr,
  input  wire logic               enableIrqInstr,
  input  wire logic               disableIrqInstr,
  input  wire logic               ccWrEn,
  input  wire logic [7:0]         ccWrData,
  input  wire logic [NV*PINS-1:0] pinIn,
  input  wire logic [NV*PINS-1:0] pinSel,
  input  wire logic [NV-1:0]      periphFlag,
  input  wire logic [NV-1:0]      periphEn,
  input  wire logic [NV-1:0]      periphClr,
  input  wire logic               prioWrEn,
  input  wire logic [1:0]         prioAddr,
  input  wire logic [7:0]         prioWrData,
  output logic [7:0]              prioRdData,
  output logic [7:0]              conditionCode,
  output logic                    entryStb,
  output logic [15:0]             entryVector,
  output logic                    entryPush,
  output logic [3:0]              entryIdx,
  output logic [NV-1:0]           pending,
  output logic                    sleeping,
  output logic                    haltMode
);

  npic_pkg::npic_state_t state_q;

  logic [7:0]      ccQ;
  logic [7:0]      vprio_q [npic_pkg::NUM_PRIO_REGS];
  logic [NV-1:0]   pend_q;
  logic [NV-1:0]   extLine_q;
  logic            haltFirst_q;
  logic [NV-1:0]   extLine;
  logic [NV-1:0]   reqNow;
  logic [NV-1:0]   enabled;
  logic [2*NV-1:0] prioFlat;
  logic [1:0]      ccCode;
  logic            takeTrap;
  logic            takeMask;
  logic            takeReset;
  logic            anyEntry;
  logic [NV-1:0]   clrOnEntry;
  logic            wakeWait;
  logic            wakeHalt;

  npic_arb_if #(.NV(NV)) arbBus ();

  npic_arbiter #(.NV(NV)) uArb (
    .arb (arbBus.arb)
  );

  assign ccCode = {ccQ[npic_pkg::CC_PRIO_HI_POS], ccQ[npic_pkg::CC_PRIO_LO_POS]}; // RL1

  // request sources
  always_comb begin
    for (int i = 0; i < NV; i++) begin
      extLine[i] = |(pinIn[i*PINS +: PINS] & pinSel[i*PINS +: PINS]); // RL15
      if (EXT_MASK[i]) begin
        reqNow[i]  = extLine[i] & ~extLine_q[i]; // RL14
        enabled[i] = |pinSel[i*PINS +: PINS];
      end else begin
        reqNow[i]  = periphFlag[i] & periphEn[i]; // RL16
        enabled[i] = periphEn[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      extLine_q <= '0;
    end else begin
      extLine_q <= extLine;
    end
  end

  // flattened priority pairs, vector i at bits 2i+1:2i
  always_comb begin
    for (int i = 0; i < NV; i++) begin
      prioFlat[2*i +: 2] = vprio_q[i / npic_pkg::PAIRS_PER_REG][2*(i % npic_pkg::PAIRS_PER_REG) +: 2]; // RL23
    end
  end

  // after halt only halt-capable sources may be chosen first
  assign arbBus.req     = pend_q & enabled & (haltFirst_q ? HALT_WAKE[NV-1:0] : {NV{1'b1}}); // RL19
  assign arbBus.lvl     = prioFlat;
  assign arbBus.curRank = npic_pkg::npic_rank(ccCode); // RL25

  assign takeReset = (state_q == npic_pkg::ST_RESET); // RL22
  assign takeTrap  = (state_q == npic_pkg::ST_RUN) && instrDone && trapInstr; // RL3 RL11
  assign takeMask  = (state_q == npic_pkg::ST_RUN) && instrDone && !trapInstr && !haltInstr && !wfiInstr
                     && arbBus.valid; // RL3 RL13
  assign anyEntry  = takeReset || takeTrap || takeMask;

  always_comb begin
    clrOnEntry = '0;
    if (takeMask) begin
      clrOnEntry[arbBus.idx] = 1'b1; // RL14
    end
  end

  // pending latches: a new request in the clearing cycle is kept
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~clrOnEntry & ~periphClr) | reqNow; // RL9 RL17
    end
  end

  // priority registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int r = 0; r < npic_pkg::NUM_PRIO_REGS; r++) begin
        vprio_q[r] <= npic_pkg::PRIO_RESET; // RL23
      end
    end else if (prioWrEn) begin
      for (int p = 0; p < npic_pkg::PAIRS_PER_REG; p++) begin
        if (prioWrData[2*p +: 2] != npic_pkg::LVL0_CODE &&
            !(prioAddr == 2'(npic_pkg::PRIO_RO_REG) && npic_pkg::PRIO_RO_MASK[2*p])) begin
          vprio_q[prioAddr][2*p +: 2] <= prioWrData[2*p +: 2]; // RL24
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prioRdData <= npic_pkg::PRIO_RESET;
    end else if (prioAddr == 2'(npic_pkg::PRIO_RO_REG)) begin
      prioRdData <= vprio_q[prioAddr] | npic_pkg::PRIO_RO_MASK; // RL23
    end else begin
      prioRdData <= vprio_q[prioAddr];
    end
  end

  // condition code: hardware entry outranks instruction updates
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ccQ <= npic_pkg::CC_RESET; // RL21
    end else if (takeReset || takeTrap) begin
      ccQ[npic_pkg::CC_PRIO_HI_POS] <= npic_pkg::LVL3_CODE[1]; // RL11
      ccQ[npic_pkg::CC_PRIO_LO_POS] <= npic_pkg::LVL3_CODE[0];
    end else if (takeMask) begin
      ccQ[npic_pkg::CC_PRIO_HI_POS] <= arbBus.lvl[2*arbBus.idx + 1]; // RL5
      ccQ[npic_pkg::CC_PRIO_LO_POS] <= arbBus.lvl[2*arbBus.idx];
    end else if (ccWrEn) begin
      ccQ <= ccWrData | npic_pkg::CC_FIXED_ONES; // RL7 RL20
    end else if (haltInstr || wfiInstr || enableIrqInstr) begin
      ccQ[npic_pkg::CC_PRIO_HI_POS] <= npic_pkg::LVL0_CODE[1]; // RL20
      ccQ[npic_pkg::CC_PRIO_LO_POS] <= npic_pkg::LVL0_CODE[0];
    end else if (disableIrqInstr) begin
      ccQ[npic_pkg::CC_PRIO_HI_POS] <= npic_pkg::LVL3_CODE[1]; // RL20
      ccQ[npic_pkg::CC_PRIO_LO_POS] <= npic_pkg::LVL3_CODE[0];
    end
  end

  assign conditionCode = ccQ;

  // entry request towards the cpu
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      entryStb    <= 1'b0;
      entryVector <= npic_pkg::VEC_RESET;
      entryPush   <= 1'b0;
      entryIdx    <= 4'h0;
    end else begin
      entryStb <= anyEntry; // RL2
      if (takeReset) begin
        entryVector <= npic_pkg::VEC_RESET; // RL22
        entryPush   <= 1'b0; // RL11
        entryIdx    <= 4'h0;
      end else if (takeTrap) begin
        entryVector <= npic_pkg::VEC_TRAP; // RL11
        entryPush   <= 1'b1; // RL4
        entryIdx    <= 4'h0;
      end else if (takeMask) begin
        entryVector <= npic_pkg::VEC_BASE - {11'h000, arbBus.idx, 1'b0}; // RL6
        entryPush   <= 1'b1; // RL4
        entryIdx    <= arbBus.idx;
      end
    end
  end

  assign pending = pend_q;

  // low-power wake decision
  assign wakeWait = |pend_q; // RL18
  assign wakeHalt = |(pend_q & HALT_WAKE[NV-1:0]); // RL18

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= npic_pkg::ST_RESET; // RL12
    end else begin
      unique case (state_q)
        npic_pkg::ST_RESET: state_q <= npic_pkg::ST_RUN;
        npic_pkg::ST_RUN: begin
          if (instrDone && haltInstr) begin
            state_q <= npic_pkg::ST_HALT;
          end else if (instrDone && wfiInstr) begin
            state_q <= npic_pkg::ST_WAIT;
          end
        end
        npic_pkg::ST_WAIT: begin
          if (wakeWait) begin
            state_q <= npic_pkg::ST_RUN; // RL18
          end
        end
        npic_pkg::ST_HALT: begin
          if (wakeHalt) begin
            state_q <= npic_pkg::ST_RUN; // RL18
          end
        end
      endcase
    end
  end

  // restricts only the first choice after halt; a masked wake source leaves it armed
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      haltFirst_q <= 1'b0;
    end else if (state_q == npic_pkg::ST_HALT && wakeHalt) begin
      haltFirst_q <= 1'b1; // RL19
    end else if (takeMask || takeTrap) begin
      haltFirst_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sleeping <= 1'b0;
      haltMode <= 1'b0;
    end else begin
      sleeping <= (state_q == npic_pkg::ST_RUN && instrDone && (haltInstr || wfiInstr)) ||
                  (state_q == npic_pkg::ST_WAIT && !wakeWait) ||
                  (state_q == npic_pkg::ST_HALT && !wakeHalt);
      haltMode <= (state_q == npic_pkg::ST_RUN && instrDone && haltInstr) ||
                  (state_q == npic_pkg::ST_HALT && !wakeHalt);
    end
  end

endmodule // npic_ctrl

// *** npic_chk.sv ***
// assertion checker for the interrupt controller ports
`timescale 1ns/100ps
module npic_chk (
  input logic        clk_sys,
  input logic        rstn,
  input logic        instrDone,
  input logic        trapInstr,
  input logic        haltInstr,
  input logic        wfiInstr,
  input logic [1:0]  prioAddr,
  input logic [7:0]  prioRdData,
  input logic [7:0]  conditionCode,
  input logic        entryStb,
  input logic [15:0] entryVector,
  input logic        entryPush,
  input logic [3:0]  entryIdx,
  input logic        sleeping,
  input logic        haltMode
);
  // level code to rank: 10->0, 01->1, 00->2, 11->3
  function automatic logic [1:0] rk(input logic [7:0] c);
    return {c[5] ~^ c[3], c[3]};
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_boundary_only: assert property (entryStb && entryVector != 16'hfffe |-> $past(instrDone))
    else $error("entry without instruction boundary");
  a_trap_entry: assert property (instrDone && trapInstr && !sleeping |=>
    entryStb && entryVector == 16'hfffc && entryPush && rk(conditionCode) == 2'h3) else $error("trap entry wrong");
  a_vector_addr: assert property (entryStb && entryPush && entryVector != 16'hfffc |->
    entryVector == 16'hfffa - {11'h0, entryIdx, 1'b0}) else $error("vector address wrong");
  a_strict_higher: assert property (entryStb && entryPush && entryVector != 16'hfffc |->
    rk(conditionCode) > rk($past(conditionCode))) else $error("entry not above current level");
  a_reset_entry: assert property ($rose(rstn) |-> ##[0:2] (entryStb && entryVector == 16'hfffe
    && !entryPush && rk(conditionCode) == 2'h3)) else $error("reset entry wrong");
  a_halt_enter: assert property (instrDone && haltInstr && !sleeping |=>
    haltMode && sleeping && conditionCode[5] && !conditionCode[3]) else $error("halt entry wrong");
  a_wfi_enter: assert property (instrDone && wfiInstr && !sleeping |=> sleeping && !haltMode)
    else $error("wait entry wrong");
  a_asleep_quiet: assert property (sleeping |=> !entryStb)
    else $error("entry while asleep");
  a_reg3_ones: assert property (prioAddr == 2'h3 |=> prioRdData[7:4] == 4'hf)
    else $error("priority register upper nibble not ones");
endmodule // npic_chk
bind npic_ctrl npic_chk u_chk (.*);

// *** npic_cpu_model.sv ***
// cpu model: offers one instruction boundary per step request
`timescale 1ns/100ps
module npic_cpu_model #(parameter int GAP = 2) (
  input  logic       clk_sys,
  input  logic       rstn,
  input  logic       step,
  input  logic [1:0] op,
  input  logic       sleeping,
  output logic       instrDone,
  output logic       trapInstr,
  output logic       haltInstr,
  output logic       wfiInstr
);
  int         cnt_q;
  logic [1:0] op_q;
  // a sleeping core executes nothing, so it offers no boundary
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 0;
      op_q  <= 2'h0;
    end else if (step) begin
      cnt_q <= GAP;
      op_q  <= op;
    end else if (cnt_q != 0 && !sleeping) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign instrDone = cnt_q == 1 && !sleeping;
  assign trapInstr = instrDone && op_q == 2'h1;
  assign haltInstr = instrDone && op_q == 2'h2;
  assign wfiInstr  = instrDone && op_q == 2'h3;
endmodule // npic_cpu_model

// *** npic_ctrl_tb_top.sv ***
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
module npic_ctrl_tb_top;
  logic        clk_sys, rstn, step, instrDone, trapInstr, haltInstr, wfiInstr;
  logic        enableIrqInstr, disableIrqInstr, ccWrEn, prioWrEn, entryStb, entryPush, sleeping, haltMode;
  logic [1:0]  op, prioAddr, c;
  logic [7:0]  ccWrData, prioWrData, prioRdData, conditionCode;
  logic [55:0] pinIn, pinSel;
  logic [13:0] periphFlag, periphEn, periphClr, pending, m;
  logic [15:0] entryVector;
  logic [3:0]  entryIdx;
  logic [1:0]  lv [14];
  int          mismatches, compares, cyc, w;
  npic_ctrl DUT (.clk_sys, .rstn, .instrDone, .trapInstr, .haltInstr, .wfiInstr, .enableIrqInstr,
    .disableIrqInstr, .ccWrEn, .ccWrData, .pinIn, .pinSel, .periphFlag, .periphEn, .periphClr, .prioWrEn,
    .prioAddr, .prioWrData, .prioRdData, .conditionCode, .entryStb, .entryVector, .entryPush, .entryIdx,
    .pending, .sleeping, .haltMode);
  npic_cpu_model #(.GAP(2)) u_cpu (.clk_sys, .rstn, .step, .op, .sleeping, .instrDone, .trapInstr,
    .haltInstr, .wfiInstr);
  function automatic int rk(input logic [1:0] k);
    return {k[1] ~^ k[0], k[0]};
  endfunction
  // reference arbiter: strictly above current rank, ties to the lower index
  function automatic int win(input logic [13:0] q, input logic [1:0] k);
    int b;
    int r;
    b = -1;
    r = rk(k);
    for (int i = 0; i < 14; i++)
      if (q[i] && rk(lv[i]) > r) begin
        b = i;
        r = rk(lv[i]);
      end
    return b;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (e !== g) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    @(negedge clk_sys);
    prioWrEn   = 1;
    prioAddr   = 2'(a);
    prioWrData = d;
    for (int j = 0; j < 4; j++)
      if (d[2*j+:2] != 2'h2 && 4*a+j < 14) lv[4*a+j] = d[2*j+:2];
    @(negedge clk_sys);
    prioWrEn = 0;
  endtask
  task automatic rd(input int a);
    logic [7:0] e;
    e = 8'hff;
    for (int j = 0; j < 4; j++)
      if (4*a+j < 14) e[2*j+:2] = lv[4*a+j];
    @(negedge clk_sys);
    prioAddr = 2'(a);
    @(negedge clk_sys);
    chk("prio", {8'h0, e}, {8'h0, prioRdData});
  endtask
  task automatic ccw(input logic [7:0] d);
    @(negedge clk_sys);
    ccWrEn   = 1;
    ccWrData = d;
    @(negedge clk_sys);
    ccWrEn = 0;
  endtask
  // one boundary of kind o; ev 0 means no entry is expected
  task automatic bnd(input logic [1:0] o, input logic [15:0] ev, input logic [1:0] el);
    logic [15:0] gv;
    gv = 16'h0;
    @(negedge clk_sys);
    step = 1;
    op   = o;
    @(negedge clk_sys);
    step = 0;
    repeat (6) begin
      @(negedge clk_sys);
      if (entryStb === 1'b1) gv = entryVector;
    end
    chk("vector", ev, gv);
    chk("level", {14'h0, el}, {14'h0, conditionCode[5], conditionCode[3]});
  endtask
  task automatic drop();
    @(negedge clk_sys);
    periphFlag = '0;
    periphClr  = '1;
    @(negedge clk_sys);
    periphClr = '0;
  endtask
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {rstn, step, op, pinIn, pinSel, periphFlag, periphEn, periphClr} = '0;
    {enableIrqInstr, disableIrqInstr, ccWrEn, ccWrData, prioWrEn, prioAddr, prioWrData} = '0;
    void'($urandom(28715));
    for (int i = 0; i < 14; i++) lv[i] = 2'h3;
    repeat (4) @(negedge clk_sys);
    rstn = 1;
    repeat (2) @(negedge clk_sys);
    chk("cc", 16'h00ea, {8'h0, conditionCode});
    for (int a = 0; a < 4; a++) rd(a);
    wr(0, 8'hcf);
    wr(0, 8'h64);
    wr(3, 8'h00);
    for (int a = 0; a < 4; a++) rd(a);
    $display("end registers");
    @(negedge clk_sys) enableIrqInstr = 1;
    @(negedge clk_sys) enableIrqInstr = 0;
    pinSel[9:8]  = 2'h3;
    periphEn[2]  = 1;
    pinIn[9]     = 1;
    repeat (2) @(negedge clk_sys);
    chk("pend", 16'h1, {15'h0, pending[2]});
    bnd(0, 16'hfff6, 2'h0);
    chk("pend", 16'h0, {15'h0, pending[2]});
    pinIn[8] = 1;
    repeat (2) @(negedge clk_sys);
    chk("pend", 16'h0, {15'h0, pending[2]});
    ccw(8'he2);
    chk("cc", 16'h00e2, {8'h0, conditionCode});
    $display("end pins");
    for (int it = 0; it < 12; it++) begin
      for (int a = 0; a < 4; a++) wr(a, 8'($urandom));
      periphFlag = 14'($urandom) & 14'h3fc3;
      periphEn   = 14'($urandom);
      ccw(8'he2);
      m = periphFlag & periphEn;
      c = 2'h2;
      repeat (5) begin
        w = win(m, c);
        bnd(0, w < 0 ? 16'h0 : 16'hfffa - 16'(2 * w), w < 0 ? c : lv[w]);
        if (w >= 0) begin
          c = lv[w];
          m[w] = 0;
          periphFlag[w] = 0;
          periphClr[w]  = 1;
          @(negedge clk_sys);
          periphClr = '0;
        end
      end
      drop();
    end
    for (int a = 0; a < 4; a++) rd(a);
    $display("end arbitration");
    wr(1, 8'h7f);
    wr(2, 8'hff);
    bnd(2, 16'h0, 2'h2);
    periphEn = 14'h0180;
    periphFlag[8] = 1;
    repeat (3) @(negedge clk_sys);
    chk("halt", 16'h1, {15'h0, haltMode});
    periphFlag[7] = 1;
    repeat (3) @(negedge clk_sys);
    chk("halt", 16'h0, {15'h0, haltMode});
    bnd(0, 16'hffec, 2'h1);
    bnd(0, 16'hffea, 2'h3);
    drop();
    @(negedge clk_sys) disableIrqInstr = 1;
    @(negedge clk_sys) disableIrqInstr = 0;
    bnd(1, 16'hfffc, 2'h3);
    $display("end halt and trap");
    // vector 1 cannot leave halt but must leave wait
    periphEn = 14'h0002;
    bnd(3, 16'h0, 2'h2);
    chk("sleep", 16'h1, {15'h0, sleeping});
    periphFlag[1] = 1;
    repeat (3) @(negedge clk_sys);
    chk("sleep", 16'h0, {15'h0, sleeping});
    bnd(0, 16'hfff8, lv[1]);
    drop();
    $display("end wait");
    bnd(2, 16'h0, 2'h2);
    rstn = 0;
    @(negedge clk_sys);
    chk("halt", 16'h0, {15'h0, haltMode});
    rstn = 1;
    repeat (2) @(negedge clk_sys);
    chk("cc", 16'h00ea, {8'h0, conditionCode});
    $display("end reset in halt");
    results();
  end
endmodule // npic_ctrl_tb_top
